/* core/mem_bus_ctrl.sv */
// Purpose: External memory bus sequencer with strobes, chip selects and byte sizing
// Assumes: All inputs except arst_n synchronous to sys_clk, which is the bus clock
// Notes: One transaction at a time; wait is sampled in T3
`timescale 1ns/1ps
module mem_bus_ctrl #(
  parameter int unsigned ADDR_W = mem_bus_pkg::ADDR_W,
  parameter int unsigned DATA_W = mem_bus_pkg::DATA_W
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire mem_bus_pkg::bus_req_s req,
  output logic req_ready,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  input wire mem_bus_pkg::cs_cfg_s cfg,
  input wire logic cfg_load,
  output mem_bus_pkg::cs_cfg_s cfg_now,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_in,
  output logic fetch_cycle_marker_n,
  output logic mem_read_strobe_n,
  output logic mem_write_strobe_n,
  output logic high_lane_enable_n,
  output logic low_lane_enable_n,
  output logic timing_ref_a_n,
  output logic timing_ref_column_n,
  output logic timing_ref_row_n,
  output logic rom_select_n,
  output logic ram_select_low_n,
  output logic ram_select_high_n,
  output logic ram_high_pin_is_cs,
  input wire logic byte_size_line_in,
  output logic byte_size_line_oe,
  output logic byte_size_line_out,
  input wire logic wait_n,
  input wire logic nmi_n,
  input wire logic [mem_bus_pkg::IRQ_W-1:0] maskable_irq_inputs,
  input wire logic [mem_bus_pkg::IRQ_W-1:0] irq_enable,
  input wire logic irq_taken,
  output logic irq_pending,
  output logic irq_is_nmi,
  output logic [1:0] irq_index
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mem_bus_pkg::bus_state_e st;
    mem_bus_pkg::bus_kind_e kind;
    logic int_ack;
    logic [ADDR_W-1:0] addr;
    logic word;
    logic second;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic rd_n;
    logic wr_n;
    logic mi_n;
    logic hen_n;
    logic len_n;
    logic ra_n;
    logic rc_n;
    logic rr_n;
    logic [DATA_W-1:0] dout;
    logic doe;
    mem_bus_pkg::cs_cfg_s cfg;
    logic nmi_prev;
    logic nmi_flag;
  } state_s;

  state_s s_q;
  state_s s_d;

  // Range match used by both decoders and sizing
  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base,
                                    input logic [ADDR_W-1:0] mask);
    in_range = ((a ^ base) & mask) == '0;
  endfunction

  logic rom_hit;
  logic ram_hit;
  logic byte_forced;
  logic mem_cycle;
  logic lane_odd;

  always_comb
  begin
    rom_hit = in_range(s_q.addr, s_q.cfg.rom_base, s_q.cfg.rom_mask);
    ram_hit = !rom_hit && in_range(s_q.addr, s_q.cfg.ram_base, s_q.cfg.ram_mask);
    mem_cycle = (s_q.st != mem_bus_pkg::ST_IDLE) && (s_q.kind != mem_bus_pkg::KIND_REFRESH);
    lane_odd = s_q.addr[0];
    // decoder pulls sizing low in its range when its byte bit is set
    byte_forced = mem_cycle && ((rom_hit && s_q.cfg.rom_byte) || (ram_hit && s_q.cfg.ram_byte));
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (cfg_load)
    begin
      s_d.cfg = cfg;
    end
    // falling edge of NMI is latched
    s_d.nmi_prev = nmi_n;
    if (s_q.nmi_prev && !nmi_n)
    begin
      s_d.nmi_flag = 1'b1;
    end
    else if (irq_taken && irq_is_nmi)
    begin
      s_d.nmi_flag = 1'b0;
    end
    unique case (s_q.st)
      mem_bus_pkg::ST_IDLE:
      begin
        if (req.valid)
        begin
          s_d.st = mem_bus_pkg::ST_T1;
          s_d.kind = req.kind;
          s_d.int_ack = req.int_ack;
          s_d.addr = req.addr;
          s_d.word = req.word;
          s_d.second = 1'b0;
          s_d.wdata = req.wdata;
          s_d.mi_n = !(req.kind == mem_bus_pkg::KIND_FETCH || req.int_ack);
          s_d.len_n = !(req.word || !req.addr[0] || req.kind == mem_bus_pkg::KIND_REFRESH);
          s_d.hen_n = !(req.word || req.addr[0] || req.kind == mem_bus_pkg::KIND_REFRESH);
          if (req.kind == mem_bus_pkg::KIND_WRITE)
          begin
            // even byte low lane, odd byte high lane
            s_d.dout = req.word ? req.wdata : (req.addr[0] ? {req.wdata[7:0], 8'h00}
                                                          : {8'h00, req.wdata[7:0]});
            s_d.doe = 1'b1;
          end
        end
      end
      mem_bus_pkg::ST_T1:
      begin
        s_d.st = mem_bus_pkg::ST_T2;
        // read strobe from end of T1
        s_d.rd_n = !(s_q.kind == mem_bus_pkg::KIND_READ || s_q.kind == mem_bus_pkg::KIND_FETCH);
        // row reference from end of T1
        s_d.rr_n = 1'b0;
      end
      mem_bus_pkg::ST_T2:
      begin
        s_d.st = mem_bus_pkg::ST_T3;
        // write strobe from end of T2
        s_d.wr_n = !(s_q.kind == mem_bus_pkg::KIND_WRITE);
        // reference A from end of T2
        s_d.ra_n = 1'b0;
      end
      mem_bus_pkg::ST_T3:
      begin
        // hold T3 while wait is low
        if (wait_n)
        begin
          s_d.st = mem_bus_pkg::ST_T4;
          // column reference from end of T3
          s_d.rc_n = 1'b0;
        end
      end
      mem_bus_pkg::ST_T4:
      begin
        // strobes released at end of T4
        s_d.rd_n = 1'b1;
        s_d.wr_n = 1'b1;
        s_d.ra_n = 1'b1;
        s_d.rc_n = 1'b1;
        s_d.rr_n = 1'b1;
        s_d.hen_n = 1'b1;
        s_d.len_n = 1'b1;
        s_d.mi_n = 1'b1;
        s_d.doe = 1'b0;
        s_d.st = mem_bus_pkg::ST_IDLE;
        // word access to byte memory moves low lane only
        if (s_q.word && byte_forced && !byte_size_line_in)
        begin
          if (!s_q.second)
          begin
            s_d.rdata[7:0] = data_in[7:0];
            // extra low-lane transaction for the odd byte
            s_d.second = 1'b1;
            s_d.addr = s_q.addr | {{(ADDR_W-1){1'b0}}, 1'b1};
            s_d.st = mem_bus_pkg::ST_T1;
            s_d.len_n = 1'b0;
            s_d.mi_n = s_q.mi_n;
            s_d.dout = {8'h00, s_q.wdata[15:8]};
            s_d.doe = s_q.kind == mem_bus_pkg::KIND_WRITE;
          end
        end
        else if (s_q.word && !s_q.second && !byte_size_line_in)
        begin
          s_d.rdata[7:0] = data_in[7:0];
          s_d.second = 1'b1;
          s_d.addr = s_q.addr | {{(ADDR_W-1){1'b0}}, 1'b1};
          s_d.st = mem_bus_pkg::ST_T1;
          s_d.len_n = 1'b0;
          s_d.mi_n = s_q.mi_n;
          s_d.dout = {8'h00, s_q.wdata[15:8]};
          s_d.doe = s_q.kind == mem_bus_pkg::KIND_WRITE;
        end
        if (s_d.st == mem_bus_pkg::ST_IDLE)
        begin
          s_d.done = 1'b1;
          if (s_q.second)
          begin
            s_d.rdata[15:8] = data_in[7:0];
          end
          else if (s_q.word)
          begin
            s_d.rdata = data_in;
          end
          else
          begin
            // odd byte comes from high lane
            s_d.rdata = {8'h00, lane_odd ? data_in[15:8] : data_in[7:0]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.st <= mem_bus_pkg::ST_IDLE;
      s_q.rd_n <= 1'b1;
      s_q.wr_n <= 1'b1;
      s_q.mi_n <= 1'b1;
      s_q.hen_n <= 1'b1;
      s_q.len_n <= 1'b1;
      s_q.ra_n <= 1'b1;
      s_q.rc_n <= 1'b1;
      s_q.rr_n <= 1'b1;
      s_q.nmi_prev <= 1'b1;
      // ROM covers top address bit zero, byte sized
      s_q.cfg.rom_base <= mem_bus_pkg::ROM_BASE_RST;
      s_q.cfg.rom_mask <= mem_bus_pkg::ROM_MASK_RST;
      s_q.cfg.rom_byte <= 1'b1;
      // RAM low select byte sized, high pin stays a port
      s_q.cfg.ram_base <= mem_bus_pkg::RAM_BASE_RST;
      s_q.cfg.ram_mask <= mem_bus_pkg::RAM_MASK_RST;
      s_q.cfg.ram_byte <= 1'b1;
      s_q.cfg.ram_high_en <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // no return-opcode decode; chained peripherals clear in-service themselves
  always_comb
  begin
    irq_is_nmi = s_q.nmi_flag;
    irq_index = 2'h0;
    irq_pending = 1'b0;
    if (s_q.nmi_flag)
    begin
      irq_pending = 1'b1;
    end
    else
    begin
      for (int i = mem_bus_pkg::IRQ_W - 1; i >= 0; i--)
      begin
        if (maskable_irq_inputs[i] && irq_enable[i])
        begin
          irq_pending = 1'b1;
          irq_index = 2'(i);
        end
      end
    end
  end

  assign req_ready = s_q.st == mem_bus_pkg::ST_IDLE;
  assign done = s_q.done;
  assign rdata = s_q.rdata;
  assign cfg_now = s_q.cfg;
  assign addr = s_q.addr;
  assign data_out = s_q.dout;
  assign data_oe = s_q.doe;
  assign fetch_cycle_marker_n = s_q.mi_n;
  assign mem_read_strobe_n = s_q.rd_n;
  assign mem_write_strobe_n = s_q.wr_n;
  assign high_lane_enable_n = s_q.hen_n;
  assign low_lane_enable_n = s_q.len_n;
  assign timing_ref_a_n = s_q.ra_n;
  assign timing_ref_column_n = s_q.rc_n;
  assign timing_ref_row_n = s_q.rr_n;
  assign byte_size_line_oe = byte_forced;
  assign byte_size_line_out = 1'b0;
  assign ram_high_pin_is_cs = s_q.cfg.ram_high_en;
  // word RAM selects gated by lane enables
  assign rom_select_n = !(mem_cycle && rom_hit);
  assign ram_select_low_n = !(mem_cycle && ram_hit &&
                              (s_q.cfg.ram_byte || !s_q.len_n));
  assign ram_select_high_n = !(mem_cycle && ram_hit && s_q.cfg.ram_high_en &&
                               !s_q.cfg.ram_byte && !s_q.hen_n);

endmodule

/* core/mem_bus_pkg.sv */
// Purpose: Shared types and constants for the external memory bus sequencer
// Assumes: One bus clock; pins active low where named _n
// Notes: Timing counts are in bus clock periods
package mem_bus_pkg;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned TOP_BIT = 23;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RESET_MIN_PERIODS = 5;
  localparam logic [3:0] RESET_MIN_CYCLES = 4'h5;

  typedef enum logic [1:0] {
    KIND_READ,
    KIND_WRITE,
    KIND_FETCH,
    KIND_REFRESH
  } bus_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_T3,
    ST_T4
  } bus_state_e;

  // Request from the core
  typedef struct packed {
    logic valid;
    bus_kind_e kind;
    logic int_ack;
    logic [ADDR_W-1:0] addr;
    logic word;
    logic [DATA_W-1:0] wdata;
  } bus_req_s;

  // Chip select configuration
  typedef struct packed {
    logic [ADDR_W-1:0] rom_base;
    logic [ADDR_W-1:0] rom_mask;
    logic rom_byte;
    logic [ADDR_W-1:0] ram_base;
    logic [ADDR_W-1:0] ram_mask;
    logic ram_byte;
    logic ram_high_en;
  } cs_cfg_s;

  localparam logic [ADDR_W-1:0] ROM_BASE_RST = 24'h000000;
  localparam logic [ADDR_W-1:0] ROM_MASK_RST = 24'h800000;
  localparam logic [ADDR_W-1:0] RAM_BASE_RST = 24'h800000;
  localparam logic [ADDR_W-1:0] RAM_MASK_RST = 24'h800000;
endpackage

/* verif/mem_bus_chk.sv */
// Purpose: Bus strobe timing checker for mem_bus_ctrl
// Assumes: One bus clock, reset asynchronous and active low
// Notes: Wait stretching is bounded at 39 cycles
`timescale 1ns/1ps
module mem_bus_chk (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wait_n,
  input wire logic fetch_cycle_marker_n,
  input wire logic mem_read_strobe_n,
  input wire logic mem_write_strobe_n,
  input wire logic high_lane_enable_n,
  input wire logic low_lane_enable_n,
  input wire logic timing_ref_a_n,
  input wire logic timing_ref_column_n,
  input wire logic timing_ref_row_n
);
  // ----
  // Strobe order
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_rd_row;
    $fell(mem_read_strobe_n) |-> $fell(timing_ref_row_n);
  endproperty
  a_rd_row: assert property (p_rd_row)
    else $error("read strobe not with row");
  property p_wr_a;
    $fell(mem_write_strobe_n) |-> $fell(timing_ref_a_n) && mem_read_strobe_n;
  endproperty
  a_wr_a: assert property (p_wr_a)
    else $error("write strobe not with ref a");
  property p_row_a;
    $fell(timing_ref_row_n) |=> $fell(timing_ref_a_n);
  endproperty
  a_row_a: assert property (p_row_a)
    else $error("ref a late after row");
  property p_a_col;
    $fell(timing_ref_a_n) |-> ##[1:40] $fell(timing_ref_column_n);
  endproperty
  a_a_col: assert property (p_a_col)
    else $error("column never follows ref a");
  property p_col_end;
    $fell(timing_ref_column_n) |=> timing_ref_column_n && timing_ref_row_n
      && timing_ref_a_n && mem_read_strobe_n && mem_write_strobe_n;
  endproperty
  a_col_end: assert property (p_col_end)
    else $error("strobes not released after T4");
  property p_lane;
    $fell(timing_ref_row_n) |-> !(low_lane_enable_n && high_lane_enable_n);
  endproperty
  a_lane: assert property (p_lane)
    else $error("no lane enabled in transaction");
  property p_wait;
    !timing_ref_a_n && timing_ref_column_n && !wait_n |=> timing_ref_column_n;
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait not honoured");
  property p_marker;
    !fetch_cycle_marker_n |-> !(low_lane_enable_n && high_lane_enable_n);
  endproperty
  a_marker: assert property (p_marker)
    else $error("marker outside transaction");
endmodule
bind mem_bus_ctrl mem_bus_chk u_mem_bus_chk (.sys_clk, .arst_n, .wait_n,
  .fetch_cycle_marker_n, .mem_read_strobe_n, .mem_write_strobe_n, .high_lane_enable_n,
  .low_lane_enable_n, .timing_ref_a_n, .timing_ref_column_n, .timing_ref_row_n);

/* verif/mem_model.sv */
// Purpose: External memory answering the bus sequencer
// Assumes: Byte at address a holds a xor 3c
// Notes: Released lanes show the inverse of the last value
`timescale 1ns/1ps
module mem_model (
  input wire logic sys_clk,
  input wire logic [23:0] addr,
  input wire logic rd_n,
  input wire logic ref_a_n,
  input wire logic lane_n,
  input wire logic byte_mem,
  input wire logic [3:0] waits,
  output logic [15:0] mem_data,
  output logic wait_n,
  output logic size_pull
);
  // ----
  // Memory
  // ----
  logic [3:0] cnt = 4'h0;
  logic [15:0] last = 16'h0;
  logic [15:0] val;
  assign val = byte_mem ? {~last[15:8], addr[7:0] ^ 8'h3c}
    : {{addr[7:1], 1'b1} ^ 8'h3c, {addr[7:1], 1'b0} ^ 8'h3c};
  assign mem_data = rd_n ? ~last : val;
  assign size_pull = byte_mem && !lane_n;
  assign wait_n = ref_a_n || cnt >= waits;
  always @(posedge sys_clk)
  begin
    cnt <= ref_a_n ? 4'h0 : cnt + 4'h1;
    if (!rd_n) last <= val;
  end
endmodule

/* verif/tb.sv */
// Purpose: Self-checking bench for mem_bus_ctrl
// Assumes: Pull-up on the byte-size line
// Notes: Latency counted from the edge taking a request
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  mem_bus_pkg::bus_req_s req = '0;
  mem_bus_pkg::cs_cfg_s cfg = '0;
  mem_bus_pkg::cs_cfg_s cfg_now;
  logic cfg_load = 1'b0, nmi_n = 1'b1, irq_taken = 1'b0, byte_mem = 1'b0, pull;
  logic req_ready, done, data_oe, fetch_cycle_marker_n, mem_read_strobe_n, mem_write_strobe_n;
  logic high_lane_enable_n, low_lane_enable_n, timing_ref_a_n, timing_ref_column_n;
  logic timing_ref_row_n, rom_select_n, ram_select_low_n, ram_select_high_n, ram_high_pin_is_cs;
  logic byte_size_line_in, byte_size_line_oe, byte_size_line_out, wait_n, irq_pending, irq_is_nmi;
  logic [1:0] irq_index;
  logic [7:0] seen;
  logic [15:0] rdata, data_out, data_in, dw;
  logic [23:0] addr;
  logic [3:0] maskable_irq_inputs = 4'h0, irq_enable = 4'h0, waits = 4'h0;
  int fails = 0, samples_checked = 0, lat;
  mem_bus_ctrl u_mem_bus_ctrl (.sys_clk(sys_clk), .arst_n(arst_n), .req(req), .req_ready(req_ready),
    .done(done), .rdata(rdata), .cfg(cfg), .cfg_load(cfg_load), .cfg_now(cfg_now), .addr(addr),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
    .fetch_cycle_marker_n(fetch_cycle_marker_n), .mem_read_strobe_n(mem_read_strobe_n),
    .mem_write_strobe_n(mem_write_strobe_n), .high_lane_enable_n(high_lane_enable_n),
    .low_lane_enable_n(low_lane_enable_n), .timing_ref_a_n(timing_ref_a_n),
    .timing_ref_column_n(timing_ref_column_n), .timing_ref_row_n(timing_ref_row_n),
    .rom_select_n(rom_select_n), .ram_select_low_n(ram_select_low_n),
    .ram_select_high_n(ram_select_high_n), .ram_high_pin_is_cs(ram_high_pin_is_cs),
    .byte_size_line_in(byte_size_line_in), .byte_size_line_oe(byte_size_line_oe),
    .byte_size_line_out(byte_size_line_out), .wait_n(wait_n), .nmi_n(nmi_n),
    .maskable_irq_inputs(maskable_irq_inputs), .irq_enable(irq_enable), .irq_taken(irq_taken),
    .irq_pending(irq_pending), .irq_is_nmi(irq_is_nmi), .irq_index(irq_index));
  mem_model u_mem_model (.sys_clk(sys_clk), .addr(addr), .rd_n(mem_read_strobe_n),
    .ref_a_n(timing_ref_a_n), .lane_n(low_lane_enable_n), .byte_mem(byte_mem), .waits(waits),
    .mem_data(data_in), .wait_n(wait_n), .size_pull(pull));
  assign byte_size_line_in = !((byte_size_line_oe && !byte_size_line_out) || pull);
  initial forever #50 sys_clk = ~sys_clk;
  // ----
  // Tasks
  // ----
  task automatic report_and_stop();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Seen bits: marker, size pull, rom, ram low, ram high, read, write, high lane
  task automatic xfer(input mem_bus_pkg::bus_kind_e k, input logic [23:0] a,
    input logic [15:0] wd, input int el, input logic w, input logic ia);
    @(posedge sys_clk);
    req <= '{1'b1, k, ia, a, w, wd};
    @(posedge sys_clk);
    req.valid <= 1'b0;
    seen = '0;
    lat = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      lat++;
      seen |= {!fetch_cycle_marker_n, byte_size_line_oe, !rom_select_n, !ram_select_low_n,
        !ram_select_high_n, !mem_read_strobe_n, !mem_write_strobe_n, !high_lane_enable_n};
      if (!mem_write_strobe_n) dw = data_out;
    end while (!done && lat < 60);
    `CHK(lat, el)
    if (!done) report_and_stop();
  endtask
  task automatic t_reset();
    `CHK(req_ready, 1'b1)
    `CHK(mem_read_strobe_n & timing_ref_row_n & low_lane_enable_n, 1'b1)
    `CHK(cfg_now.rom_mask, 24'h800000)
    `CHK(ram_high_pin_is_cs, 1'b0)
  endtask
  task automatic t_rom();
    // Forced byte sizing means byte-wide parts on the low lane
    byte_mem <= 1'b1;
    xfer(mem_bus_pkg::KIND_FETCH, 24'h000124, 16'h0000, 8, 1'b1, 1'b0);
    `CHK(seen[7], 1'b1)
    `CHK(seen[6], 1'b1)
    `CHK(byte_size_line_out, 1'b0)
    `CHK(seen[5], 1'b1)
    `CHK(rdata, 16'h2524 ^ 16'h3c3c)
    `CHK(addr, 24'h000125)
  endtask
  task automatic t_ram();
    xfer(mem_bus_pkg::KIND_READ, 24'h800042, 16'h0000, 8, 1'b1, 1'b0);
    `CHK(seen[7], 1'b0)
    `CHK(seen[4:3], 2'b10)
    `CHK(rdata, 16'h4342 ^ 16'h3c3c)
    byte_mem = 1'b0;
  endtask
  task automatic t_cfg();
    @(posedge sys_clk);
    cfg <= '{24'h0, 24'h800000, 1'b0, 24'h800000, 24'h800000, 1'b0, 1'b1};
    cfg_load <= 1'b1;
    @(posedge sys_clk);
    cfg_load <= 1'b0;
    xfer(mem_bus_pkg::KIND_READ, 24'h800042, 16'h0000, 4, 1'b1, 1'b0);
    `CHK(seen[6], 1'b0)
    `CHK(ram_high_pin_is_cs, 1'b1)
    `CHK(seen[3], 1'b1)
    `CHK(seen[4], 1'b1)
    `CHK(rdata, 16'h4342 ^ 16'h3c3c)
    xfer(mem_bus_pkg::KIND_WRITE, 24'h800050, 16'h1234, 4, 1'b1, 1'b0);
    `CHK(seen[2:0], 3'b011)
    `CHK(dw, 16'h1234)
    `CHK(data_oe, 1'b0)
  endtask
  task automatic t_byte_wait();
    byte_mem = 1'b1;
    xfer(mem_bus_pkg::KIND_READ, 24'h800060, 16'h0000, 8, 1'b1, 1'b0);
    `CHK(rdata, 16'h6160 ^ 16'h3c3c)
    byte_mem = 1'b0;
    waits = 4'h2;
    xfer(mem_bus_pkg::KIND_READ, 24'h800070, 16'h0000, 6, 1'b1, 1'b0);
    waits = 4'h0;
    // Odd byte read flagged as acknowledge: high lane only, marker low
    xfer(mem_bus_pkg::KIND_READ, 24'h800071, 16'h0000, 4, 1'b0, 1'b1);
    `CHK(rdata, 16'h0071 ^ 16'h003c)
    `CHK(seen[7], 1'b1)
    `CHK(seen[0], 1'b1)
    xfer(mem_bus_pkg::KIND_REFRESH, 24'h800080, 16'h0000, 4, 1'b1, 1'b0);
    `CHK(seen[2:0], 3'b001)
  endtask
  task automatic t_irq();
    @(posedge sys_clk);
    maskable_irq_inputs <= 4'b1010;
    irq_enable <= 4'hf;
    repeat (3) @(negedge sys_clk);
    `CHK({irq_is_nmi, irq_index}, 3'b001)
    `CHK(irq_pending, 1'b1)
    @(posedge sys_clk);
    nmi_n <= 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK(irq_is_nmi, 1'b1)
    @(posedge sys_clk);
    irq_taken <= 1'b1;
    @(posedge sys_clk);
    irq_taken <= 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK({irq_is_nmi, irq_index}, 3'b001)
  endtask
  // ----
  // Sequence
  // ----
  initial
  begin
    repeat (8) @(posedge sys_clk);
    t_reset();
    arst_n <= 1'b1;
    t_rom();
    t_ram();
    t_cfg();
    t_byte_wait();
    t_irq();
    report_and_stop();
  end
endmodule
